// *** design/tsens_params.svh ***
`ifndef TSENS_PARAMS_SVH
`define TSENS_PARAMS_SVH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define TSENS_OFF_STATUS 12'h000
`define TSENS_OFF_LOCAL_LIMIT 12'h004
`define TSENS_OFF_REMOTE_LIMIT 12'h008
`define TSENS_OFF_POINTER 12'h00C
`define TSENS_OFF_CTRL 12'h010
`define TSENS_OFF_IRQ_STATUS 12'h014
`define TSENS_OFF_IRQ_ENABLE 12'h018
`define TSENS_OFF_IRQ_CLEAR 12'h01C
`define TSENS_OFF_ADDR 12'h020
// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define TSENS_BIT_BUSY 7
`define TSENS_BIT_LOCAL 6
`define TSENS_BIT_REMOTE 4
`define TSENS_BIT_OPEN 2
// ----------------------------------------
// Reset values and addresses
// ----------------------------------------
`define TSENS_LOCAL_LIMIT_RST 8'h46
`define TSENS_REMOTE_LIMIT_RST 8'h78
`define TSENS_POINTER_RST 8'h00
`define TSENS_ALERT_ADDR 7'h0C
`define TSENS_ADDR_BASE 7'h48
// ----------------------------------------
// Timing
// ----------------------------------------
`define TSENS_CLK_HZ 10000000
`define TSENS_CONV_HZ 4
`define TSENS_CONV_CYCLES (`TSENS_CLK_HZ / `TSENS_CONV_HZ)
`define TSENS_BUSY_CYCLES 16
`endif

// *** design/tsens_pkg.sv ***
package tsens_pkg;
  typedef enum logic [1:0] {
    TSENS_IDLE = 2'b00,
    TSENS_CONV = 2'b01
  } tsens_state_t;
endpackage

// *** design/tsens_rate_div.sv ***
`timescale 1ns/1ps
`include "tsens_params.svh"
module tsens_rate_div #(
  parameter int unsigned PERIOD = `TSENS_CONV_CYCLES
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Strobe
  output logic tick
);
  logic [31:0] cnt_r;
  // Free running, never stalled by lockout so the rate stays fixed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 32'h0000_0000;
    end else if (cnt_r == PERIOD - 1) begin
      cnt_r <= 32'h0000_0000;
    end else begin
      cnt_r <= cnt_r + 32'h0000_0001;
    end
  end
  assign tick = (cnt_r == PERIOD - 1); // RL17 RL9
endmodule

// *** design/tsens_core.sv ***
`timescale 1ns/1ps
`include "tsens_params.svh"
// Function
// RL1: Status register shows limit exceedances, conversion busy and open remote junction.
// RL2: After reset all flags read zero unless an alarm is present.
// RL3: Status read clears flags only if overtemperature has already ended.
// RL4: One fixed strapped slave address from eight variants, not programmable.
// RL5: Device also answers the alert response address.
// RL6: Supply loss resets all register contents; operation resumes afterwards.
// RL7: No conversion starts while supply lockout is active.
// RL8: Alarm output released and its latch cleared at power-up.
// RL9: Autonomous conversions start four times per second.
// RL10: Command pointer resets to zero, selecting local temperature.
// RL11: Local high limit resets to seventy degrees.
// RL12: Remote high limit resets to one hundred twenty degrees.
// RL13: Alarm latched; released by status read after fault or alert response.
// RL14: Busy bit7, local bit6, remote bit4, open bit2; others zero.
// RL15: Limits are unsigned whole degrees; seventy reads 46 hex.
// RL16: Host queries alert address; device answers with its own address.
// RL17: Free-running divider issues conversion start strobe every period.
// RL18: Flag set in the same cycle as a clearing read stays set.
module tsens_core #(
  parameter int unsigned CONV_CYCLES = `TSENS_CONV_CYCLES,
  parameter logic [2:0] ADDR_SEL = 3'h0
) (
  // AHB-Lite slave
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Supply monitors
  input wire logic supply_ok,
  input wire logic supply_lockout,
  // Measurement front end
  input wire logic [7:0] local_temp,
  input wire logic [7:0] remote_temp,
  input wire logic diode_open,
  output logic conv_start,
  // Alert response from link
  input wire logic alert_resp,
  output logic [6:0] alert_addr_out,
  // Alarm pin and interrupt
  output logic alarm_out,
  output logic alarm_oe,
  output logic irq
);
  // ----------------------------------------
  // Reset combining
  // ----------------------------------------
  logic rst_n;
  assign rst_n = hresetn & supply_ok; // RL6
  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic ph_wr_r, ph_rd_r;
  logic [11:0] ph_addr_r;
  logic take;
  assign take = hsel & hready & htrans[1];
  always_ff @(posedge hclk or negedge rst_n) begin
    if (!rst_n) begin
      ph_wr_r <= 1'b0;
      ph_rd_r <= 1'b0;
      ph_addr_r <= 12'h000;
    end else begin
      ph_wr_r <= take & hwrite;
      ph_rd_r <= take & ~hwrite;
      ph_addr_r <= haddr;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  logic rd_status;
  assign rd_status = take & ~hwrite & (haddr == `TSENS_OFF_STATUS);
  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  logic tick;
  tsens_rate_div #(.PERIOD(CONV_CYCLES)) u_div (
    .hclk(hclk),
    .hresetn(rst_n),
    .tick(tick)
  );
  tsens_pkg::tsens_state_t st_r;
  logic [7:0] busy_cnt_r;
  logic conv_done;
  logic run_stop_r;
  always_ff @(posedge hclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= tsens_pkg::TSENS_IDLE;
      busy_cnt_r <= 8'h00;
    end else begin
      case (st_r)
        tsens_pkg::TSENS_IDLE: begin
          if (tick && !supply_lockout && !run_stop_r) begin // RL7 RL9
            st_r <= tsens_pkg::TSENS_CONV;
            busy_cnt_r <= 8'h00;
          end
        end
        tsens_pkg::TSENS_CONV: begin
          busy_cnt_r <= busy_cnt_r + 8'h01;
          if (busy_cnt_r == 8'(`TSENS_BUSY_CYCLES - 1)) begin
            st_r <= tsens_pkg::TSENS_IDLE;
          end
        end
        default: st_r <= tsens_pkg::TSENS_IDLE;
      endcase
    end
  end
  assign conv_start = (st_r == tsens_pkg::TSENS_IDLE) & tick & ~supply_lockout & ~run_stop_r;
  assign conv_done = (st_r == tsens_pkg::TSENS_CONV) &
                     (busy_cnt_r == 8'(`TSENS_BUSY_CYCLES - 1));
  // ----------------------------------------
  // Limits, pointer and control
  // ----------------------------------------
  logic [7:0] local_limit_r, remote_limit_r, pointer_r;
  always_ff @(posedge hclk or negedge rst_n) begin
    if (!rst_n) begin
      local_limit_r <= `TSENS_LOCAL_LIMIT_RST; // RL11 RL15
      remote_limit_r <= `TSENS_REMOTE_LIMIT_RST; // RL12
      pointer_r <= `TSENS_POINTER_RST; // RL10
      run_stop_r <= 1'b0;
    end else if (ph_wr_r) begin
      case (ph_addr_r)
        `TSENS_OFF_LOCAL_LIMIT: local_limit_r <= hwdata[7:0];
        `TSENS_OFF_REMOTE_LIMIT: remote_limit_r <= hwdata[7:0];
        `TSENS_OFF_POINTER: pointer_r <= hwdata[7:0];
        `TSENS_OFF_CTRL: run_stop_r <= hwdata[0];
        default: ;
      endcase
    end
  end
  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  logic local_over_flag_r, remote_over_flag_r, open_flag_r;
  logic local_hot, remote_hot, fault_now, clr_ok;
  assign local_hot = conv_done & (local_temp > local_limit_r);
  assign remote_hot = conv_done & (remote_temp > remote_limit_r);
  // Limit faults are judged at the last conversion, diode_open at the live input
  logic local_cond_r, remote_cond_r;
  always_ff @(posedge hclk or negedge rst_n) begin
    if (!rst_n) begin
      local_cond_r <= 1'b0;
      remote_cond_r <= 1'b0;
    end else if (conv_done) begin
      local_cond_r <= local_temp > local_limit_r;
      remote_cond_r <= remote_temp > remote_limit_r;
    end
  end
  assign fault_now = local_cond_r | remote_cond_r | diode_open;
  assign clr_ok = rd_status & ~fault_now; // RL3
  always_ff @(posedge hclk or negedge rst_n) begin
    if (!rst_n) begin
      local_over_flag_r <= 1'b0; // RL2
      remote_over_flag_r <= 1'b0;
      open_flag_r <= 1'b0;
    end else begin
      local_over_flag_r <= local_hot | (local_over_flag_r & ~clr_ok); // RL18
      remote_over_flag_r <= remote_hot | (remote_over_flag_r & ~clr_ok); // RL18
      open_flag_r <= (conv_done & diode_open) | (open_flag_r & ~clr_ok);
    end
  end
  logic [7:0] status;
  always_comb begin
    status = 8'h00; // RL14
    status[`TSENS_BIT_BUSY] = (st_r == tsens_pkg::TSENS_CONV); // RL1
    status[`TSENS_BIT_LOCAL] = local_over_flag_r;
    status[`TSENS_BIT_REMOTE] = remote_over_flag_r;
    status[`TSENS_BIT_OPEN] = open_flag_r;
  end
  // ----------------------------------------
  // Alarm latch and alert response
  // ----------------------------------------
  logic [6:0] own_addr;
  assign own_addr = `TSENS_ADDR_BASE | {4'h0, ADDR_SEL}; // RL4
  logic alarm_r;
  logic alarm_set;
  // Diode faults never drive the alarm pin
  assign alarm_set = local_hot | remote_hot;
  always_ff @(posedge hclk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_r <= 1'b0; // RL8
    end else if (alarm_set) begin
      alarm_r <= 1'b1;
    end else if (clr_ok || (alert_resp && alarm_r)) begin
      alarm_r <= 1'b0; // RL13
    end
  end
  // Open drain: drive low only while latched
  assign alarm_out = 1'b0;
  assign alarm_oe = alarm_r;
  assign alert_addr_out = alarm_r ? own_addr : 7'h00; // RL5 RL16
  // ----------------------------------------
  // Interrupt registers
  // ----------------------------------------
  logic [2:0] irq_stat_r, irq_en_r, irq_ev, irq_clr;
  assign irq_ev = {conv_done, local_hot | remote_hot, conv_done & diode_open};
  assign irq_clr = (ph_wr_r && ph_addr_r == `TSENS_OFF_IRQ_CLEAR) ? hwdata[2:0] : 3'h0;
  always_ff @(posedge hclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_r <= 3'h0;
    end else begin
      irq_stat_r <= irq_ev | (irq_stat_r & ~irq_clr);
    end
  end
  always_ff @(posedge hclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_en_r <= 3'h0;
    end else if (ph_wr_r && ph_addr_r == `TSENS_OFF_IRQ_ENABLE) begin
      irq_en_r <= hwdata[2:0];
    end
  end
  assign irq = |(irq_stat_r & irq_en_r);
  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [31:0] rdata_r;
  always_ff @(posedge hclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      case (haddr)
        `TSENS_OFF_STATUS: rdata_r <= {24'h00_0000, status};
        `TSENS_OFF_LOCAL_LIMIT: rdata_r <= {24'h00_0000, local_limit_r};
        `TSENS_OFF_REMOTE_LIMIT: rdata_r <= {24'h00_0000, remote_limit_r};
        `TSENS_OFF_POINTER: rdata_r <= {24'h00_0000, pointer_r};
        `TSENS_OFF_CTRL: rdata_r <= {31'h0000_0000, run_stop_r};
        `TSENS_OFF_IRQ_STATUS: rdata_r <= {29'h0000_0000, irq_stat_r};
        `TSENS_OFF_IRQ_ENABLE: rdata_r <= {29'h0000_0000, irq_en_r};
        `TSENS_OFF_ADDR: rdata_r <= {25'h000_0000, own_addr};
        default: rdata_r <= 32'h0000_0000;
      endcase
    end
  end
  assign hrdata = rdata_r;
endmodule

// *** dv/tsens_core_asserts.sv ***
`timescale 1ns/1ps
`include "tsens_params.svh"
module tsens_core_asserts #(
  parameter int unsigned CONV_CYCLES = 64,
  parameter logic [2:0] ADDR_SEL = 3'h0
) (
  // Bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Device pins
  input wire logic supply_ok,
  input wire logic supply_lockout,
  input wire logic conv_start,
  input wire logic alert_resp,
  input wire logic [6:0] alert_addr_out,
  input wire logic alarm_oe,
  input wire logic irq
);
  // ----
  // Checks
  // ----
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn || !supply_ok);
  int unsigned gap_r;
  logic seen_r;
  wire st_go = hsel && hready && htrans[1] && !hwrite && haddr == `TSENS_OFF_STATUS;
  sequence s_rd;
    st_go ##1 1'b1;
  endsequence
  // Ticks lost to lockout give a multiple of the period
  always_ff @(posedge hclk or negedge hresetn or negedge supply_ok) begin
    if (!hresetn || !supply_ok) begin
      gap_r <= 0;
      seen_r <= 1'b0;
    end else begin
      gap_r <= conv_start ? 1 : gap_r + 1;
      seen_r <= seen_r | conv_start;
    end
  end
  AST_LOCK: assert property (supply_lockout |-> !conv_start)
    else $error("start under lockout");
  AST_RATE: assert property (conv_start && seen_r |-> gap_r >= CONV_CYCLES
    && gap_r % CONV_CYCLES == 0) else $error("start off period");
  AST_PWRUP: assert property ((!$past(hresetn) || !$past(supply_ok))
    |-> !alarm_oe && !irq) else $error("alarm after reset");
  AST_SUPPLY: assert property (disable iff (!hresetn) !supply_ok
    |-> !alarm_oe && !irq && !conv_start) else $error("state kept in supply loss");
  AST_ADDR: assert property (alert_addr_out
    == (alarm_oe ? `TSENS_ADDR_BASE + ADDR_SEL : 7'h00)) else $error("bad alert addr");
  AST_ALERT_CLR: assert property (alert_resp |-> ##[1:2] !alarm_oe)
    else $error("alarm kept after response");
  AST_LATCH: assert property ($fell(alarm_oe) |-> $past(alert_resp)
    || $past(alert_resp, 2) || $past(st_go) || $past(st_go, 2)) else $error("alarm dropped");
  AST_RSVD: assert property (s_rd |-> (hrdata & 32'hFFFF_FF2B) == 32'h0000_0000)
    else $error("reserved status bit set");
endmodule
bind tsens_core tsens_core_asserts #(.CONV_CYCLES(CONV_CYCLES), .ADDR_SEL(ADDR_SEL))
  tsens_core_asserts_i (.*);

// *** dv/tsens_host_mdl.sv ***
`timescale 1ns/1ps
module tsens_host_mdl (
  // Bench side
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic req,
  input wire logic [3:0] dly,
  output logic [6:0] addr_q,
  output logic done,
  // Alert link
  input wire logic [6:0] alert_addr_out,
  output logic alert_resp
);
  int cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= -1;
      done <= 1'b0;
      alert_resp <= 1'b0;
      addr_q <= 7'h00;
    end else begin
      cnt <= req ? int'(dly) : (cnt < 0 ? -1 : cnt - 1);
      done <= (cnt == 0);
      // Only an answered query completes the protocol
      alert_resp <= (cnt == 0) && (alert_addr_out != 7'h00);
      if (cnt == 0) addr_q <= alert_addr_out;
    end
  end
endmodule

// *** dv/tsens_core_bench.sv ***
`timescale 1ns/1ps
`include "tsens_params.svh"
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin error_cnt++; \
  $display("ERROR %s exp %h got %h", nm, e, s); end end
module tsens_core_bench;
  localparam int unsigned CONV = 64;
  localparam logic [2:0] SEL = 3'h6;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, supply_ok = 1, supply_lockout = 0;
  logic diode_open = 0, req = 0, al = 0, flt = 0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic [3:0] dly = 4'h0;
  logic [7:0] local_temp = 8'h00, remote_temp = 8'h00, fl = 8'h00, lim = 8'h46;
  logic [31:0] hwdata = 32'h0000_0000, hrdata, q;
  logic [6:0] alert_addr_out, addr_q;
  logic hreadyout, hresp, conv_start, alert_resp, alarm_out, alarm_oe, irq, done;
  logic [11:0] ra[6] = '{`TSENS_OFF_LOCAL_LIMIT, `TSENS_OFF_REMOTE_LIMIT,
    `TSENS_OFF_POINTER, `TSENS_OFF_ADDR, 12'h030, `TSENS_OFF_IRQ_CLEAR};
  logic [31:0] rv[6] = '{32'h46, 32'h78, 32'h0, 32'h48 + SEL, 32'h0, 32'h0};
  int error_cnt = 0, n_tests = 0, seed = 32'h7f97, n;
  tsens_core #(.CONV_CYCLES(CONV), .ADDR_SEL(SEL)) tsens_core_i (.hready(hreadyout), .*);
  tsens_host_mdl tsens_host_mdl_i (.*);
  always #50 hclk = ~hclk;
  // Reference flags, updated mid-conversion while the bench keeps inputs still
  always @(posedge hclk) begin
    if (conv_start === 1'b1) begin
      repeat (8) @(posedge hclk);
      flt = (local_temp > lim) || (remote_temp > 8'h78);
      fl = fl | {1'b0, (local_temp > lim), 1'b0, (remote_temp > 8'h78), 1'b0, diode_open, 2'b0};
      al = al | (local_temp > lim) | (remote_temp > 8'h78);
    end
  end
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  task automatic st(input logic b);
    ahb(1'b0, `TSENS_OFF_STATUS, 32'h0, q);
    `CHK("status", {24'h0, fl | {b, 7'h0}}, q)
    // Diode judged live at the read, limits at the last conversion
    if (!flt && !diode_open) begin
      fl = 8'h00;
      al = 1'b0;
    end
    @(posedge hclk);
    `CHK("alarm", al, alarm_oe)
    `CHK("alarm pin", 1'b0, alarm_out)
  endtask
  task automatic conv(input logic [7:0] lt, input logic [7:0] rt, input logic op);
    local_temp <= lt;
    remote_temp <= rt;
    diode_open <= op;
    @(posedge hclk);
    repeat (200) if (conv_start !== 1'b1) @(posedge hclk);
    st(1'b1);
    repeat (20) @(posedge hclk);
  endtask
  task automatic alr();
    req <= 1'b1;
    dly <= 4'($random(seed));
    @(posedge hclk);
    req <= 1'b0;
    repeat (40) if (done !== 1'b1) @(posedge hclk);
    `CHK("alert addr", al ? `TSENS_ADDR_BASE + SEL : 7'h0, addr_q)
    al = 1'b0;
    repeat (2) @(posedge hclk);
    `CHK("alarm", al, alarm_oe)
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    st(1'b0);
    ahb(1'b1, `TSENS_OFF_ADDR, 32'($random(seed)), q);
    foreach (ra[i]) begin
      ahb(1'b0, ra[i], 32'h0, q);
      `CHK("reset value", rv[i], q)
    end
    for (int i = 0; i < 6; i++) begin
      lim = 8'($random(seed));
      ahb(1'b1, `TSENS_OFF_LOCAL_LIMIT, {24'h0, lim}, q);
      ahb(1'b0, `TSENS_OFF_LOCAL_LIMIT, 32'h0, q);
      `CHK("limit", {24'h0, lim}, q)
      conv(8'($random(seed)), 8'($random(seed)), 1'($random(seed)));
      if (i % 2) alr();
      else st(1'b0);
    end
    ahb(1'b1, `TSENS_OFF_IRQ_CLEAR, 32'h7, q);
    ahb(1'b1, `TSENS_OFF_IRQ_ENABLE, 32'h4, q);
    @(posedge hclk);
    `CHK("irq", 1'b0, irq)
    conv(8'h00, 8'hFF, 1'b0);
    `CHK("irq", 1'b1, irq)
    ahb(1'b1, `TSENS_OFF_IRQ_CLEAR, 32'h4, q);
    `CHK("alarm", 1'b1, alarm_oe)
    @(posedge hclk);
    `CHK("irq", 1'b0, irq)
    supply_ok <= 1'b0;
    repeat (2) @(posedge hclk);
    supply_ok <= 1'b1;
    {fl, al, flt, lim} = {8'h00, 1'b0, 1'b0, 8'h46};
    ahb(1'b0, `TSENS_OFF_LOCAL_LIMIT, 32'h0, q);
    `CHK("limit", 32'h46, q)
    `CHK("alarm", 1'b0, alarm_oe)
    for (int k = 0; k < 3; k++) begin
      supply_lockout <= (k == 1);
      // Standby stops starts while the divider keeps running
      if (k == 2) ahb(1'b1, `TSENS_OFF_CTRL, 32'h1, q);
      n = 0;
      repeat (4 * CONV) begin
        @(posedge hclk);
        n += (conv_start === 1'b1);
      end
      `CHK("starts", k ? 0 : 4, n)
    end
    summarize();
  end
  initial begin
    #(4000 * 100);
    error_cnt++;
    summarize();
  end
endmodule
